// ==== dac_serial_host.sv ====
`timescale 1ns/1ns
`include "dac_host_regs.svh"

// Command buffer; DEPTH must be a power of two so pointers wrap
module cmd_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// Draining side
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      count_ff;
	wire              push = in_valid & in_ready;
	wire              pop = out_valid & out_ready;
	wire  [AW:0]      nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

	// Read side looks straight at the head entry
	assign out_valid = count_ff != '0;
	assign out_data = mem[rd_ff];

	// Registered ready keeps the user port glitch free
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ff <= '0;
			rd_ff <= '0;
			count_ff <= '0;
			in_ready <= 1'b1;
		end else begin
			wr_ff <= push ? AW'(wr_ff + 1'b1) : wr_ff;
			rd_ff <= pop ? AW'(rd_ff + 1'b1) : rd_ff;
			count_ff <= nxt_count;
			in_ready <= nxt_count != (AW+1)'(DEPTH);
		end
	end

	// Storage has no reset
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ff] <= in_data;
		end
	end
endmodule // cmd_fifo

// How it works
// - Host sends 24 clocks per chained device, 32 in long frames
// - Gated burst, frame select rises after it
// - Host leaves bypass by pulsing reset pin
// - Address byte then data word, MSB first
// - Top bit set marks a read request
// - Follow read with no-op to fetch data
// - Load pulse waits minimum after select rise
// - Checked frames are 32 bits with CRC
// - Host appends CRC; device returns CRC
// - Unchecked long frames pad top eight bits
// - Never end a frame short of count
module dac_serial_host #(
	parameter int CHAIN_LEN  = 1,
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// Command stream, one word per chained device
	input  wire dac_host_pkg::cmd_type cmd_word,
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	// Mode controls
	input  wire logic                 crc_en,
	input  wire logic                 pad_long,
	input  wire logic                 load_sync,
	input  wire logic                 clear_req,
	input  wire logic                 hw_reset_req,
	// Status
	output logic                      busy,
	output logic [31:0]               rd_data,
	output logic                      rd_valid,
	// Device pins
	output logic                      sync_n,
	output logic                      sclk,
	output logic                      serial_in,
	output logic                      output_load_n,
	output logic                      output_clear,
	output logic                      dev_reset_n,
	input  wire logic                 serial_out
);
	// CRC remainder, MSB first; zero on a clean checked frame
	function automatic logic [7:0] crc8_of(input logic [31:0] d);
		logic [7:0] c;
		logic       fb;
		c = `CRC_INIT;
		for (int i = 31; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	dac_host_pkg::state_type state_ff, nxt_state;
	logic [7:0]  cnt_ff, nxt_cnt;
	logic [5:0]  bit_ff, nxt_bit;
	logic [3:0]  word_ff, nxt_word;
	logic [31:0] tx_ff, nxt_tx;
	logic [31:0] rx_ff, nxt_rx;
	logic        long_ff, nxt_long;
	logic        nxt_sync_n, nxt_sclk, nxt_sin, nxt_load_n, nxt_rst_n;
	logic        nxt_rd_valid;
	logic        so_meta_ff, so_ff;
	logic        pop;
	logic        head_valid;
	dac_host_pkg::cmd_type head;

	cmd_fifo #(.WIDTH(`FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (sys_clk),
		.reset     (reset),
		.in_data   (cmd_word),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.out_data  (head),
		.out_valid (head_valid),
		.out_ready (pop)
	);

	// Frame assembly: checked, padded long, or plain short
	wire        tick = cnt_ff == 8'h00;
	wire [23:0] head_bits = head;
	wire        long_now = crc_en | pad_long;
	// Checked frame ends in CRC byte
	wire [7:0]  head_crc = crc8_of({`PAD_BITS'(0), head_bits});
	wire [31:0] frame_crc = {head_bits, head_crc};
	// Unchecked long frame, zero top byte
	wire [31:0] frame_pad = {`PAD_BITS'(0), head_bits};
	wire [31:0] frame_short = {head_bits, `PAD_BITS'(0)};
	wire [31:0] frame_now = crc_en ? frame_crc :
		(pad_long ? frame_pad : frame_short);
	wire [5:0]  last_bit = long_ff ? 6'(`LONG_BITS - 1) :
		6'(`FRAME_BITS - 1);
	wire        last_word = word_ff == 4'(CHAIN_LEN - 1);
	wire [7:0]  half_cnt = 8'(`SCLK_HALF_CYC - 1);

	// Sequencer; sclk idles high so the first edge is a fall
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = tick ? 8'h00 : 8'(cnt_ff - 1'b1);
		nxt_bit = bit_ff;
		nxt_word = word_ff;
		nxt_tx = tx_ff;
		nxt_rx = rx_ff;
		nxt_long = long_ff;
		nxt_sync_n = sync_n;
		nxt_sclk = sclk;
		nxt_sin = serial_in;
		nxt_load_n = output_load_n;
		nxt_rst_n = dev_reset_n;
		nxt_rd_valid = 1'b0;
		pop = 1'b0;
		unique case (state_ff)
			dac_host_pkg::ST_IDLE: begin
				nxt_sync_n = 1'b1;
				nxt_sclk = 1'b1;
				// Async mode holds load low ahead of select rise
				nxt_load_n = load_sync;
				if (hw_reset_req) begin
					nxt_rst_n = 1'b0;
					nxt_cnt = 8'(`RST_LOW_CYC - 1);
					nxt_state = dac_host_pkg::ST_RST;
				end else if (head_valid) begin
					nxt_state = dac_host_pkg::ST_LOAD;
				end
			end
			dac_host_pkg::ST_LOAD: begin
				if (head_valid) begin
					pop = 1'b1;
					nxt_tx = frame_now;
					nxt_long = long_now;
					nxt_bit = 6'h00;
					nxt_sync_n = 1'b0;
					nxt_sin = frame_now[31];
					nxt_cnt = half_cnt;
					nxt_state = dac_host_pkg::ST_SHIFT;
				end
			end
			dac_host_pkg::ST_SHIFT: begin
				if (tick && sclk) begin
					nxt_sclk = 1'b0;
					nxt_cnt = half_cnt;
				end else if (tick) begin
					// Rise: capture returned bit, launch next
					nxt_sclk = 1'b1;
					nxt_cnt = half_cnt;
					nxt_rx = {rx_ff[30:0], so_ff};
					nxt_tx = {tx_ff[30:0], 1'b0};
					nxt_sin = tx_ff[30];
					nxt_bit = 6'(bit_ff + 1'b1);
					if (bit_ff == last_bit) begin
						nxt_word = last_word ? 4'h0 : 4'(word_ff + 1'b1);
						nxt_state = last_word ? dac_host_pkg::ST_GAP :
							dac_host_pkg::ST_LOAD;
					end
				end
			end
			dac_host_pkg::ST_GAP: begin
				if (tick) begin
					nxt_sync_n = 1'b1;
					nxt_rd_valid = 1'b1;
					nxt_cnt = 8'(`LOAD_DELAY_CYC - 1);
					nxt_state = dac_host_pkg::ST_LWAIT;
				end
			end
			dac_host_pkg::ST_LWAIT: begin
				if (tick && load_sync) begin
					nxt_load_n = 1'b0;
					nxt_cnt = 8'(`LOAD_PULSE_CYC - 1);
					nxt_state = dac_host_pkg::ST_LPULS;
				end else if (tick) begin
					nxt_state = dac_host_pkg::ST_IDLE;
				end
			end
			dac_host_pkg::ST_LPULS: begin
				if (tick) begin
					nxt_load_n = 1'b1;
					nxt_state = dac_host_pkg::ST_IDLE;
				end
			end
			dac_host_pkg::ST_RST: begin
				if (tick) begin
					nxt_rst_n = 1'b1;
					nxt_state = dac_host_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = dac_host_pkg::ST_IDLE;
			end
		endcase
	end

	// Returned data crosses in through two flops
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			so_meta_ff <= 1'b0;
			so_ff <= 1'b0;
		end else begin
			so_meta_ff <= serial_out;
			so_ff <= so_meta_ff;
		end
	end

	// Sequencer state
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_ff <= dac_host_pkg::ST_IDLE;
			cnt_ff <= 8'h00;
			bit_ff <= 6'h00;
			word_ff <= 4'h0;
			tx_ff <= 32'h0;
			rx_ff <= 32'h0;
			long_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			bit_ff <= nxt_bit;
			word_ff <= nxt_word;
			tx_ff <= nxt_tx;
			rx_ff <= nxt_rx;
			long_ff <= nxt_long;
		end
	end

	// Pins and status; readback is the last frame's bits
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sync_n <= 1'b1;
			sclk <= 1'b1;
			serial_in <= 1'b0;
			output_load_n <= 1'b1;
			output_clear <= 1'b0;
			dev_reset_n <= 1'b1;
			busy <= 1'b0;
			rd_data <= 32'h0;
			rd_valid <= 1'b0;
		end else begin
			sync_n <= nxt_sync_n;
			sclk <= nxt_sclk;
			serial_in <= nxt_sin;
			output_load_n <= nxt_load_n;
			output_clear <= clear_req;
			dev_reset_n <= nxt_rst_n;
			busy <= nxt_state != dac_host_pkg::ST_IDLE;
			rd_data <= nxt_rd_valid ? rx_ff : rd_data;
			rd_valid <= nxt_rd_valid;
		end
	end

	// Checking helpers: falling clocks per frame, time since rise
	logic [9:0] fall_cnt_ff;
	logic [7:0] since_ff;
	wire  [9:0] exp_falls = long_ff ? 10'(`LONG_BITS * CHAIN_LEN) :
		10'(`FRAME_BITS * CHAIN_LEN);
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			fall_cnt_ff <= 10'h000;
			since_ff <= 8'h00;
		end else begin
			fall_cnt_ff <= sync_n ? 10'h000 :
				10'(fall_cnt_ff + (sclk & !nxt_sclk));
			since_ff <= !sync_n ? 8'h00 :
				(since_ff == 8'hff ? since_ff : 8'(since_ff + 1'b1));
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_frame_len;
		$rose(sync_n) |-> fall_cnt_ff == exp_falls;
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame clock count wrong");
	property p_idle_high;
		sync_n |-> sclk;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("clock moved outside frame");
	property p_sin_stable;
		!sclk |-> $stable(serial_in);
	endproperty
	a_sin_stable: assert property (p_sin_stable)
		else $error("data changed while clock low");
	property p_read_msb;
		pop && !crc_en && !pad_long |=> serial_in == $past(head.read);
	endproperty
	a_read_msb: assert property (p_read_msb)
		else $error("read flag not sent first");
	property p_crc_ok;
		state_ff == dac_host_pkg::ST_SHIFT && bit_ff == 6'h00 &&
			$past(crc_en) && long_ff |-> crc8_of(tx_ff) == 8'h00;
	endproperty
	a_crc_ok: assert property (p_crc_ok)
		else $error("frame check byte wrong");
	property p_crc_len;
		pop && crc_en |=> long_ff;
	endproperty
	a_crc_len: assert property (p_crc_len)
		else $error("checked frame not long");
	property p_pad;
		pop && pad_long && !crc_en |=> tx_ff[31:24] == 8'h00;
	endproperty
	a_pad: assert property (p_pad)
		else $error("long frame top byte not zero");
	property p_rst_pulse;
		$fell(dev_reset_n) |-> !dev_reset_n[*8];
	endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("reset pulse too short");
	property p_load_delay;
		$fell(output_load_n) && state_ff == dac_host_pkg::ST_LPULS |->
			since_ff >= 8'(`LOAD_DELAY_CYC);
	endproperty
	a_load_delay: assert property (p_load_delay)
		else $error("load pulse too early");
	property p_rd_after;
		$rose(sync_n) |-> rd_valid ##1 !rd_valid;
	endproperty
	a_rd_after: assert property (p_rd_after)
		else $error("readback strobe misplaced");

	c_read: cover property (pop && head.read);
	c_crc: cover property (rd_valid && long_ff && crc_en);
	c_load: cover property ($fell(output_load_n) && load_sync);
	c_rst: cover property ($rose(dev_reset_n));
endmodule // dac_serial_host

// ==== dac_host_regs.svh ====
`ifndef DAC_HOST_REGS_SVH
`define DAC_HOST_REGS_SVH

// Frame geometry
`define FRAME_BITS 24
`define LONG_BITS 32
`define PAD_BITS 8
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

// Clock rate and link timing in nanoseconds
`define CLK_PERIOD_NS 10
`define SCLK_HALF_NS 40
`define LOAD_DELAY_NS 100
`define LOAD_PULSE_NS 50
`define RST_LOW_NS 100

// Derived cycle counts, least times rounded up
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOAD_DELAY_CYC ((`LOAD_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOAD_PULSE_CYC ((`LOAD_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_LOW_CYC ((`RST_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== dac_host_pkg.sv ====
package dac_host_pkg;

	// One device command: read flag, register address, data word
	typedef struct packed {
		logic        read;
		logic [6:0]  addr;
		logic [15:0] data;
	} cmd_type;

	// Gray codes along idle, load, shift, gap, wait, pulse
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_LOAD  = 3'h1,
		ST_SHIFT = 3'h3,
		ST_GAP   = 3'h2,
		ST_LWAIT = 3'h6,
		ST_LPULS = 3'h7,
		ST_RST   = 3'h4
	} state_type;

endpackage

// ==== dac_device_model.sv ====
`timescale 1ns/1ns
// Behavioural device: shift register, register file, output latch
module dac_device_model (
	// Link pins
	input  wire logic   sync_n,
	input  wire logic   sclk,
	input  wire logic   serial_in,
	input  wire logic   output_load_n,
	input  wire logic   output_clear,
	input  wire logic   dev_reset_n,
	output logic        serial_out,
	// Observation
	input  wire logic   check_en,
	output logic [23:0] last_word,
	output logic [15:0] dac_out,
	output logic        crc_err,
	output int          frames
);
	logic [15:0] regs [0:127];
	logic [31:0] sr = 32'h0;
	logic [23:0] rb, w;
	logic        bypass, rd_pend, load_pend;
	logic        so_ff = 1'h0;
	int          cnt = 0;

	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--)
			c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	// released line shows no stale bit
	assign serial_out = (sync_n || !dev_reset_n || regs[3][4]) ? ~so_ff :
		(bypass ? serial_in : so_ff);

	task automatic defaults();
		for (int i = 0; i < 128; i++)
			regs[i] = 16'h0000;
		bypass = 1'h0;
		rd_pend = 1'h0;
		load_pend = 1'h0;
		crc_err = 1'h0;
		dac_out = 16'h0000;
	endtask
	initial begin
		frames = 0;
		last_word = 24'h000000;
		defaults();
	end
	always @(negedge dev_reset_n)
		defaults();
	always @(negedge check_en)
		crc_err = 1'h0;

	always @(negedge sync_n) begin
		cnt = 0;
		if (rd_pend && dev_reset_n)
			sr = check_en ? {rb, crc8({8'h00, rb})} : {8'h00, rb};
		rd_pend = 1'h0;
		so_ff = sr[check_en ? 31 : 23];
	end
	always @(negedge sclk)
		if (!sync_n && dev_reset_n && !bypass) begin
			sr = {sr[30:0], serial_in};
			cnt++;
		end
	always @(posedge sclk)
		if (!sync_n)
			so_ff = sr[check_en ? 31 : 23];

	always @(posedge sync_n) begin
		w = check_en ? sr[31:8] : sr[23:0];
		if (dev_reset_n && !bypass && cnt >= (check_en ? 32 : 24)) begin
			if (check_en && crc8(sr) != 8'h00)
				crc_err = 1'h1;
			else begin
				frames++;
				last_word = w;
				rd_pend = w[23];
				rb = {w[23:16], regs[w[22:16]]};
				if (!w[23])
					regs[w[22:16]] = w[15:0];
				if (!w[23] && w[22:16] == 7'h02)
					bypass = w[3];
				// load pin already low, else await pulse
				if (!w[23] && w[22:16] == 7'h05 && !output_clear) begin
					if (!output_load_n)
						dac_out = w[15:0];
					else
						load_pend = 1'h1;
				end
			end
		end
	end
	// deferred load, ignored under clear
	// Data written under clear is not new data once clear falls
	always @(negedge output_load_n)
		if (!output_clear && dev_reset_n && load_pend) begin
			dac_out = regs[5];
			load_pend = 1'h0;
		end
	always @(posedge output_clear) begin
		dac_out = 16'h0000;
		load_pend = 1'h0;
	end
endmodule // dac_device_model

// ==== tb_dac_serial_host.sv ====
`timescale 1ns/1ns
// Host controller against a behavioural device
module tb_dac_serial_host;
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	dac_host_pkg::cmd_type cmd_word;
	logic cmd_valid, cmd_ready, crc_en, pad_long, load_sync, clear_req;
	logic hw_reset_req, busy, rd_valid, sync_n, sclk, serial_in;
	logic output_load_n, output_clear, dev_reset_n, serial_out;
	logic check_en, crc_err;
	logic [31:0] rd_data;
	logic [23:0] last_word, w1, w2;
	logic [15:0] dac_out;
	logic [15:0] lfsr = 16'h0ef5;
	logic [24:0] notes [$];
	int frames, f0, n;
	int fails = 0;
	int checks = 0;
	int cyc = 0;

	dac_serial_host #(.CHAIN_LEN(1), .FIFO_DEPTH(32)) u_dac_serial_host (
		.sys_clk, .reset, .cmd_word, .cmd_valid, .cmd_ready, .crc_en,
		.pad_long, .load_sync, .clear_req, .hw_reset_req, .busy, .rd_data,
		.rd_valid, .sync_n, .sclk, .serial_in, .output_load_n, .output_clear,
		.dev_reset_n, .serial_out);
	dac_device_model u_dac_device_model (.sync_n, .sclk, .serial_in,
		.output_load_n, .output_clear, .dev_reset_n, .serial_out,
		.check_en, .last_word, .dac_out, .crc_err, .frames);

	always #5 sys_clk = ~sys_clk;

	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Shifter with taps 16 14 13 11
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	// Hold one word until taken; valid stays up for back-to-back use
	task automatic send(input logic [23:0] w, input logic chk,
		input logic [23:0] e);
		cmd_word <= w;
		cmd_valid <= 1'h1;
		do
			@(posedge sys_clk);
		while (cmd_ready !== 1'h1);
		notes.push_back({chk, e});
	endtask
	// Wait out every frame and load pulse
	task automatic drain();
		cmd_valid <= 1'h0;
		repeat (3)
			@(posedge sys_clk);
		while (busy !== 1'h0 || notes.size() != 0)
			@(posedge sys_clk);
	endtask

	// Cut a hang short; the run needs under 20000 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			finish_test();
		end
	end
	// Compare each echoed word with the oldest note when that note has its chk bit set
	always @(posedge sys_clk)
		if (rd_valid === 1'h1) begin
			if (notes.size() == 0)
				check("rd_valid", 32'h1, 32'h0);
			else if (notes[0][24])
				check("rd_data", rd_data[23:0], notes[0][23:0]);
			if (notes.size() != 0)
				notes.delete(0);
		end

	initial begin
		cmd_word = 24'h000000;
		cmd_valid = 1'h0;
		crc_en = 1'h0;
		pad_long = 1'h0;
		load_sync = 1'h0;
		clear_req = 1'h0;
		hw_reset_req = 1'h0;
		check_en = 1'h0;
		repeat (16)
			@(posedge sys_clk);
		reset <= 1'h0;
		@(posedge sys_clk);
		// Back to back: write, write, read, no-op fetch
		w1 = {8'h05, rnd()};
		send(w1, 1'h0, w1);
		send(24'h090123, 1'h1, w1);
		send(24'h850000, 1'h1, 24'h090123);
		send(24'h000000, 1'h1, {8'h85, w1[15:0]});
		drain();
		check("dac_out", dac_out, w1[15:0]);
		check("last_word", last_word, 24'h000000);
		// Synchronous load holds the output until the pulse
		load_sync <= 1'h1;
		w2 = {8'h05, rnd()};
		send(w2, 1'h0, w2);
		cmd_valid <= 1'h0;
		do
			@(posedge sys_clk);
		while (rd_valid !== 1'h1);
		check("dac_out", dac_out, w1[15:0]);
		drain();
		check("dac_out", dac_out, w2[15:0]);
		// Clear swallows the load pulse and stays after release
		clear_req <= 1'h1;
		send({8'h05, rnd()}, 1'h1, w2);
		drain();
		check("dac_out", dac_out, 16'h0000);
		clear_req <= 1'h0;
		repeat (3)
			@(posedge sys_clk);
		check("dac_out", dac_out, 16'h0000);
		// Pass-through echoes the frame and ignores it
		send(24'h020008, 1'h0, w2);
		w1 = {8'h05, rnd()};
		send(w1, 1'h1, w1);
		drain();
		check("dac_out", dac_out, 16'h0000);
		hw_reset_req <= 1'h1;
		@(posedge sys_clk);
		hw_reset_req <= 1'h0;
		repeat (2)
			@(posedge sys_clk);
		check("dev_reset_n", dev_reset_n, 1'h0);
		drain();
		send(w1, 1'h0, w1);
		drain();
		check("dac_out", dac_out, w1[15:0]);
		// Checked frames, then padded long frames
		crc_en <= 1'h1;
		check_en <= 1'h1;
		w1 = {8'h05, rnd()};
		send(w1, 1'h0, w1);
		drain();
		check("crc_err", crc_err, 1'h0);
		check("last_word", last_word, w1);
		// Unchecked frame into a checking device is refused
		crc_en <= 1'h0;
		pad_long <= 1'h1;
		send(24'h000001, 1'h0, 24'h000000);
		drain();
		check("crc_err", crc_err, 1'h1);
		check("last_word", last_word, w1);
		check_en <= 1'h0;
		repeat (2)
			@(posedge sys_clk);
		check("crc_err", crc_err, 1'h0);
		w1 = {8'h09, rnd()};
		send(w1, 1'h0, w1);
		drain();
		check("last_word", last_word, w1);
		pad_long <= 1'h0;
		// Fill the buffer until it refuses, then drain it
		f0 = frames;
		n = 0;
		cmd_word <= 24'h0a0000;
		cmd_valid <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (cmd_ready === 1'h1) begin
				n++;
				notes.push_back(25'h0);
			end
		end while (cmd_ready === 1'h1);
		check("accepted", n >= 32, 1'h1);
		drain();
		check("frames", frames - f0, n);
		finish_test();
	end
endmodule // tb_dac_serial_host
